//--- hdl/embedded_ram_block.sv
// Embedded RAM block with clock-mode enables, read-during-write handling and FIFO use.
//
// Decided for this implementation: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
module embedded_ram_block (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Global clock enable, freezes all state while low
  input wire logic ce_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  // ----------------------------------------------------------------
  // Software-visible state
  // ----------------------------------------------------------------
  ram_pkg::mem_mode_t mem_mode_reg; // Memory organisation.
  ram_pkg::clk_mode_t clk_mode_reg; // Clock arrangement.
  logic dc_reg; // Mixed-port don't-care option.
  logic oreg_a_reg; // Port A output register in use.
  logic oreg_b_reg; // Port B output register in use.
  logic [3:0] clken_reg; // Four group enable bits.
  logic [ram_pkg::ADDR_W-1:0] addr_a_reg;
  logic [ram_pkg::ADDR_W-1:0] addr_b_reg;
  logic [ram_pkg::DATA_W-1:0] wdata_a_reg;
  logic [ram_pkg::DATA_W-1:0] wdata_b_reg;
  logic [3:0] byteen_reg; // Byte enables, A low pair, B high pair.
  logic coll_reg; // Last issued pair collided across ports.

  // ----------------------------------------------------------------
  // FIFO bookkeeping
  // ----------------------------------------------------------------
  logic [ram_pkg::ADDR_W-1:0] wptr_reg;
  logic [ram_pkg::ADDR_W-1:0] rptr_reg;
  logic [ram_pkg::CNT_W-1:0] count_reg;
  logic fifo_empty;
  logic fifo_full;

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  logic ack_reg;
  logic [31:0] dat_reg;
  logic req;
  logic wr_fire;
  logic rd_take;
  logic [7:0] reg_adr;
  logic [31:0] wmask;
  logic [31:0] wval_ctrl;
  logic [31:0] rd_mux;

  // ----------------------------------------------------------------
  // Per-port signals
  // ----------------------------------------------------------------
  logic a_in_en;
  logic a_out_en;
  logic b_in_en;
  logic b_out_en;
  logic cmd_fire;
  logic [3:0] cmd;
  ram_pkg::port_op_t op_a_next;
  ram_pkg::port_op_t op_b_next;
  ram_pkg::port_op_t iss_a;
  ram_pkg::port_op_t iss_b;
  logic [ram_pkg::DATA_W-1:0] rdata_a;
  logic [ram_pkg::DATA_W-1:0] rdata_b;
  logic [ram_pkg::DATA_W-1:0] dout_a;
  logic [ram_pkg::DATA_W-1:0] dout_b;
  logic mixed_dc;
  logic is_fifo;

  assign is_fifo = (mem_mode_reg == ram_pkg::MEM_FIFO);
  assign fifo_empty = (count_reg == '0);
  assign fifo_full = (count_reg == ram_pkg::FIFO_DEPTH);

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // One wait state: ack rises the cycle after the request and drops the
  // cycle after that, so back-to-back strobes each see a fresh ack.
  assign req = wb_cyc_i & wb_stb_i;
  assign wr_fire = req & wb_we_i & ack_reg;
  assign rd_take = req & ~wb_we_i & ~ack_reg;
  assign reg_adr = {wb_adr_i[7:2], 2'b00};
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Acknowledge every access, mapped or not.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else if (ce_i) begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // Read data is captured in the request cycle and held through the ack.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= '0;
    end else if (ce_i && rd_take) begin
      dat_reg <= rd_mux;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // Read multiplexer; unmapped offsets and the command register read zero.
  always_comb begin
    rd_mux = '0;
    case (reg_adr)
      ram_pkg::REG_CTRL: begin
        rd_mux[6:0] = {oreg_b_reg, oreg_a_reg, dc_reg, clk_mode_reg, mem_mode_reg};
      end
      ram_pkg::REG_CLKEN: begin
        rd_mux[3:0] = clken_reg;
      end
      ram_pkg::REG_ADDR: begin
        rd_mux[ram_pkg::ADDR_W-1:0] = addr_a_reg;
        rd_mux[ram_pkg::PORT_B_LSB +: ram_pkg::ADDR_W] = addr_b_reg;
      end
      ram_pkg::REG_WDATA: begin
        rd_mux = {wdata_b_reg, wdata_a_reg};
      end
      ram_pkg::REG_BYTEEN: begin
        rd_mux[3:0] = byteen_reg;
      end
      ram_pkg::REG_RDATA: begin
        rd_mux = {dout_b, dout_a};
      end
      ram_pkg::REG_STATUS: begin
        rd_mux[ram_pkg::CNT_W-1:0] = count_reg;
        rd_mux[ram_pkg::STAT_EMPTY_BIT] = fifo_empty;
        rd_mux[ram_pkg::STAT_FULL_BIT] = fifo_full;
        rd_mux[ram_pkg::STAT_COLL_BIT] = coll_reg;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------
  // An illegal pairing of clock mode and memory mode is stored as single
  // clock, which every memory mode accepts, so the block never runs in a
  // combination it cannot honour.
  assign wval_ctrl = wb_dat_i & wmask;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {oreg_b_reg, oreg_a_reg, dc_reg} <= ram_pkg::CTRL_RESET[6:4];
      mem_mode_reg <= ram_pkg::mem_mode_t'(ram_pkg::CTRL_RESET[1:0]);
      clk_mode_reg <= ram_pkg::clk_mode_t'(ram_pkg::CTRL_RESET[3:2]);
    end else if (ce_i && wr_fire && reg_adr == ram_pkg::REG_CTRL && wb_sel_i[0]) begin
      mem_mode_reg <= ram_pkg::mem_mode_t'(wval_ctrl[ram_pkg::CTRL_MEM_LSB +: 2]);
      dc_reg <= wval_ctrl[ram_pkg::CTRL_DC_BIT];
      oreg_a_reg <= wval_ctrl[ram_pkg::CTRL_OREG_A_BIT];
      oreg_b_reg <= wval_ctrl[ram_pkg::CTRL_OREG_B_BIT];
      if (wval_ctrl[ram_pkg::CTRL_CLK_LSB +: 2] == ram_pkg::CLK_INDEP &&
          wval_ctrl[ram_pkg::CTRL_MEM_LSB +: 2] != ram_pkg::MEM_TDP) begin
        clk_mode_reg <= ram_pkg::CLK_SINGLE;
      end else if (wval_ctrl[ram_pkg::CTRL_CLK_LSB +: 2] == ram_pkg::CLK_RW &&
                   wval_ctrl[ram_pkg::CTRL_MEM_LSB +: 2] != ram_pkg::MEM_SDP &&
                   wval_ctrl[ram_pkg::CTRL_MEM_LSB +: 2] != ram_pkg::MEM_FIFO) begin
        clk_mode_reg <= ram_pkg::CLK_SINGLE;
      end else begin
        clk_mode_reg <= ram_pkg::clk_mode_t'(wval_ctrl[ram_pkg::CTRL_CLK_LSB +: 2]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Plain data registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clken_reg <= ram_pkg::CLKEN_RESET;
      byteen_reg <= ram_pkg::BYTEEN_RESET;
      addr_a_reg <= '0;
      addr_b_reg <= '0;
      wdata_a_reg <= '0;
      wdata_b_reg <= '0;
    end else if (ce_i && wr_fire) begin
      if (reg_adr == ram_pkg::REG_CLKEN && wb_sel_i[0]) begin
        clken_reg <= wb_dat_i[3:0];
      end
      if (reg_adr == ram_pkg::REG_BYTEEN && wb_sel_i[0]) begin
        byteen_reg <= wb_dat_i[3:0];
      end
      if (reg_adr == ram_pkg::REG_ADDR) begin
        if (wb_sel_i[0]) begin
          addr_a_reg <= wb_dat_i[ram_pkg::ADDR_W-1:0];
        end
        if (wb_sel_i[2]) begin
          addr_b_reg <= wb_dat_i[ram_pkg::PORT_B_LSB +: ram_pkg::ADDR_W];
        end
      end
      if (reg_adr == ram_pkg::REG_WDATA) begin
        wdata_a_reg <= (wdata_a_reg & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
        wdata_b_reg <= (wdata_b_reg & ~wmask[31:16]) | (wb_dat_i[31:16] & wmask[31:16]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Register group enables per clock mode
  // ----------------------------------------------------------------
  // All groups share clk_i here; the clock modes survive as the way the
  // four enable bits are shared out among the port register groups.
  always_comb begin
    a_in_en = clken_reg[0];
    a_out_en = clken_reg[0];
    b_in_en = clken_reg[0];
    b_out_en = clken_reg[0];
    case (clk_mode_reg)
      ram_pkg::CLK_INDEP: begin
        a_in_en = clken_reg[0];
        a_out_en = clken_reg[0];
        b_in_en = clken_reg[1];
        b_out_en = clken_reg[1];
      end
      ram_pkg::CLK_IO: begin
        a_in_en = clken_reg[0];
        a_out_en = clken_reg[1];
        b_in_en = clken_reg[2];
        b_out_en = clken_reg[3];
      end
      ram_pkg::CLK_RW: begin
        a_in_en = clken_reg[0];
        a_out_en = clken_reg[0];
        b_in_en = clken_reg[1];
        b_out_en = clken_reg[1];
      end
      ram_pkg::CLK_SINGLE: begin
        a_in_en = clken_reg[0];
        a_out_en = clken_reg[0];
        b_in_en = clken_reg[0];
        b_out_en = clken_reg[0];
      end
      default: begin
        a_in_en = 1'b0;
        a_out_en = 1'b0;
        b_in_en = 1'b0;
        b_out_en = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Command decode into port operations
  // ----------------------------------------------------------------
  // Commands the memory mode has no port for are dropped silently.
  assign cmd_fire = wr_fire & (reg_adr == ram_pkg::REG_CMD) & wb_sel_i[0];
  assign cmd = wb_dat_i[3:0];

  always_comb begin
    op_a_next = '0;
    op_b_next = '0;
    op_a_next.addr = addr_a_reg;
    op_a_next.wdata = wdata_a_reg;
    op_a_next.be = byteen_reg[1:0];
    op_b_next.addr = addr_b_reg;
    op_b_next.wdata = wdata_b_reg;
    op_b_next.be = byteen_reg[3:2];
    case (mem_mode_reg)
      ram_pkg::MEM_TDP: begin
        op_a_next.we = cmd[ram_pkg::CMD_A_WR_BIT];
        op_a_next.re = cmd[ram_pkg::CMD_A_RD_BIT];
        op_b_next.we = cmd[ram_pkg::CMD_B_WR_BIT];
        op_b_next.re = cmd[ram_pkg::CMD_B_RD_BIT];
      end
      ram_pkg::MEM_SDP: begin
        op_a_next.we = cmd[ram_pkg::CMD_A_WR_BIT];
        op_b_next.re = cmd[ram_pkg::CMD_B_RD_BIT];
      end
      ram_pkg::MEM_SP: begin
        op_a_next.we = cmd[ram_pkg::CMD_A_WR_BIT];
        op_a_next.re = cmd[ram_pkg::CMD_A_RD_BIT];
      end
      ram_pkg::MEM_FIFO: begin
        // A pop on an empty FIFO is refused, so push and pop together on
        // an empty buffer degrade to a lone push.
        op_a_next.we = cmd[ram_pkg::CMD_A_WR_BIT] & ~fifo_full;
        op_a_next.addr = wptr_reg;
        op_a_next.be = '1;
        op_b_next.re = cmd[ram_pkg::CMD_B_RD_BIT] & ~fifo_empty;
        op_b_next.addr = rptr_reg;
      end
      default: begin
        op_a_next.we = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // FIFO pointers
  // ----------------------------------------------------------------
  // Pointers move only when the port group actually captures the command.
  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && wr_fire && reg_adr == ram_pkg::REG_CTRL && wb_sel_i[0])) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end else if (ce_i && cmd_fire && is_fifo) begin
      if (op_a_next.we && a_in_en) begin
        wptr_reg <= wptr_reg + 8'h01;
      end
      if (op_b_next.re && b_in_en) begin
        rptr_reg <= rptr_reg + 8'h01;
      end
      count_reg <= count_reg + ram_pkg::CNT_W'(op_a_next.we && a_in_en)
                             - ram_pkg::CNT_W'(op_b_next.re && b_in_en);
    end
  end

  // ----------------------------------------------------------------
  // Port register groups and array
  // ----------------------------------------------------------------
  port_stage u_port_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .in_en_i(a_in_en),
    .out_en_i(a_out_en),
    .out_reg_sel_i(oreg_a_reg & ~is_fifo),
    .load_i(cmd_fire),
    .op_i(op_a_next),
    .rdata_i(rdata_a),
    .op_o(iss_a),
    .dout_o(dout_a)
  );

  port_stage u_port_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .in_en_i(b_in_en),
    .out_en_i(b_out_en),
    .out_reg_sel_i(oreg_b_reg & ~is_fifo),
    .load_i(cmd_fire),
    .op_i(op_b_next),
    .rdata_i(rdata_b),
    .op_o(iss_b),
    .dout_o(dout_b)
  );

  // Collisions between differently clocked ports have no defined answer,
  // so they read as the same undefined value as the don't-care option.
  assign mixed_dc = dc_reg | (clk_mode_reg != ram_pkg::CLK_SINGLE);

  ram_array u_array (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .op_a_i(iss_a),
    .op_b_i(iss_b),
    .dc_i(mixed_dc),
    .rdata_a_o(rdata_a),
    .rdata_b_o(rdata_b)
  );

  // ----------------------------------------------------------------
  // Collision status
  // ----------------------------------------------------------------
  // Updated on every issued operation; shows whether a read in the most recent
  // pair met a write to the same address on the other port.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      coll_reg <= 1'b0;
    end else if (ce_i && (iss_a.we || iss_a.re || iss_b.we || iss_b.re)) begin
      coll_reg <= (iss_a.addr == iss_b.addr) &&
                  ((iss_a.we && iss_b.re) || (iss_b.we && iss_a.re));
    end
  end

endmodule

//--- hdl/ram_pkg.sv
// Package with register map, field layout, modes and carriers for the embedded RAM block.
package ram_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int BE_W = 2;
  localparam int CNT_W = 9;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CLKEN = 8'h04;
  localparam logic [7:0] REG_ADDR = 8'h08;
  localparam logic [7:0] REG_WDATA = 8'h0c;
  localparam logic [7:0] REG_BYTEEN = 8'h10;
  localparam logic [7:0] REG_CMD = 8'h14;
  localparam logic [7:0] REG_RDATA = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_MEM_LSB = 0;
  localparam int CTRL_CLK_LSB = 2;
  localparam int CTRL_DC_BIT = 4;
  localparam int CTRL_OREG_A_BIT = 5;
  localparam int CTRL_OREG_B_BIT = 6;
  localparam int PORT_B_LSB = 16;
  localparam int CMD_A_WR_BIT = 0;
  localparam int CMD_A_RD_BIT = 1;
  localparam int CMD_B_WR_BIT = 2;
  localparam int CMD_B_RD_BIT = 3;
  localparam int STAT_EMPTY_BIT = 9;
  localparam int STAT_FULL_BIT = 10;
  localparam int STAT_COLL_BIT = 11;

  // ----------------------------------------------------------------
  // Reset values and FIFO depth
  // ----------------------------------------------------------------
  localparam logic [6:0] CTRL_RESET = 7'h0c;
  localparam logic [3:0] CLKEN_RESET = 4'hf;
  localparam logic [3:0] BYTEEN_RESET = 4'hf;
  localparam logic [CNT_W-1:0] FIFO_DEPTH = 9'h100;

  // Memory modes.
  typedef enum logic [1:0] {
    MEM_TDP = 2'h0,
    MEM_SDP = 2'h1,
    MEM_SP = 2'h2,
    MEM_FIFO = 2'h3
  } mem_mode_t;

  // Clock modes.
  typedef enum logic [1:0] {
    CLK_INDEP = 2'h0,
    CLK_IO = 2'h1,
    CLK_RW = 2'h2,
    CLK_SINGLE = 2'h3
  } clk_mode_t;

  // One port operation as it travels into the array.
  typedef struct packed {
    logic we;
    logic re;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [BE_W-1:0] be;
  } port_op_t;

endpackage

//--- hdl/ram_array.sv
// Storage array with two byte-writable ports and registered read data.
`timescale 1ns/1ps
module ram_array (
  // Clock, reset and global enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Operations already gated by their group enables
  input wire ram_pkg::port_op_t op_a_i,
  input wire ram_pkg::port_op_t op_b_i,
  // Mixed-port collisions read as undefined (zero) when set
  input wire logic dc_i,
  // Read data registers
  output logic [ram_pkg::DATA_W-1:0] rdata_a_o,
  output logic [ram_pkg::DATA_W-1:0] rdata_b_o
);

  // Contents are never cleared; only clocked writes change them.
  logic [ram_pkg::DATA_W-1:0] mem [0:(1 << ram_pkg::ADDR_W)-1];
  ram_pkg::port_op_t ops [2];

  assign ops[0] = op_a_i;
  assign ops[1] = op_b_i;

  // ----------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------
  // Port B is applied last, so a same-address double write keeps B; the
  // stored value is not promised to the user in that case.
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      for (int p = 0; p < 2; p++) begin
        for (int b = 0; b < ram_pkg::BE_W; b++) begin
          if (ops[p].we && ops[p].be[b]) begin
            mem[ops[p].addr][b*8 +: 8] <= ops[p].wdata[b*8 +: 8];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path, one copy per port
  // ----------------------------------------------------------------
  for (genvar p = 0; p < 2; p++) begin : g_rd
    logic [ram_pkg::DATA_W-1:0] rd_reg;
    // Reads the old array word since the write above is non-blocking.
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        rd_reg <= '0;
      end else if (ce_i && ops[p].re) begin
        if (ops[p].we) begin
          // Same port: new data flows through, masked lanes read zero.
          for (int b = 0; b < ram_pkg::BE_W; b++) begin
            rd_reg[b*8 +: 8] <= ops[p].be[b] ? ops[p].wdata[b*8 +: 8] : 8'h00;
          end
        end else if (ops[1-p].we && ops[1-p].addr == ops[p].addr) begin
          rd_reg <= dc_i ? '0 : mem[ops[p].addr];
        end else begin
          rd_reg <= mem[ops[p].addr];
        end
      end
      // With no read the word stays as it was.
    end
  end

  assign rdata_a_o = g_rd[0].rd_reg;
  assign rdata_b_o = g_rd[1].rd_reg;

endmodule

//--- hdl/port_stage.sv
// Input and output register groups of one memory port with their enables.
`timescale 1ns/1ps
module port_stage (
  // Clock, reset and global enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Group enables and output register choice
  input wire logic in_en_i,
  input wire logic out_en_i,
  input wire logic out_reg_sel_i,
  // New operation from the command decoder
  input wire logic load_i,
  input wire ram_pkg::port_op_t op_i,
  // Array side
  input wire logic [ram_pkg::DATA_W-1:0] rdata_i,
  output ram_pkg::port_op_t op_o,
  output logic [ram_pkg::DATA_W-1:0] dout_o
);

  ram_pkg::port_op_t op_reg; // Captured address, data and enables.
  logic [ram_pkg::DATA_W-1:0] out_reg; // Optional output register.

  // ----------------------------------------------------------------
  // Input register group
  // ----------------------------------------------------------------
  // A held operation waits while the group is disabled and fires once the
  // enable returns; a command offered while disabled is not captured.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_reg <= '0;
    end else if (ce_i && in_en_i) begin
      if (load_i) begin
        op_reg <= op_i;
      end else begin
        op_reg.we <= 1'b0;
        op_reg.re <= 1'b0;
      end
    end
  end

  // The array acts only on edges where the input group is clocked.
  always_comb begin
    op_o = op_reg;
    op_o.we = op_reg.we & in_en_i & ce_i;
    op_o.re = op_reg.re & in_en_i & ce_i;
  end

  // ----------------------------------------------------------------
  // Output register group
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_reg <= '0;
    end else if (ce_i && out_en_i) begin
      out_reg <= rdata_i;
    end
  end

  // Bypass shows the array's read register directly.
  assign dout_o = out_reg_sel_i ? out_reg : rdata_i;

endmodule

//--- tb/embedded_ram_block_chk.sv
// Bus-side assertions of the embedded RAM block.
`timescale 1ns/1ps
module embedded_ram_block_chk (
  // Clock, reset and enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o
);
  // ----
  // Properties
  // ----
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A request taken at this edge, and the reads among them.
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i; endsequence
  sequence s_rd; s_req ##0 !wb_we_i; endsequence
  property p_ack; s_req |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_pulse; wb_ack_o && ce_i |=> !wb_ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack too long");
  property p_idle; !(wb_cyc_i && wb_stb_i) && ce_i |=> !wb_ack_o; endproperty
  a_idle: assert property (p_idle) else $error("stray ack");
  property p_rst; $fell(rst_i) |-> wb_dat_o == 32'h0 && !wb_ack_o; endproperty
  a_rst: assert property (p_rst) else $error("output not zero after reset");
  property p_hold;
    !(wb_cyc_i && wb_stb_i && !wb_we_i && ce_i) |=> $stable(wb_dat_o);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_void;
    s_rd ##0 (wb_adr_i >= 8'h20 || wb_adr_i[7:2] == 6'h05) |=> wb_dat_o == 32'h0;
  endproperty
  a_void: assert property (p_void) else $error("void read not zero");
  property p_frz; !ce_i |=> $stable(wb_ack_o) && $stable(wb_dat_o); endproperty
  a_frz: assert property (p_frz) else $error("state moved while disabled");
  property p_rdw; s_rd ##1 ce_i |-> wb_ack_o ##1 !wb_ack_o; endproperty
  a_rdw: assert property (p_rdw) else $error("read answer shape");
endmodule
bind embedded_ram_block embedded_ram_block_chk i_chk (.clk_i(clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

//--- tb/wb_user.sv
// User logic model that drives the block as a bus master.
`timescale 1ns/1ps
module wb_user (
  // Clock and answer
  input wire logic clk_i,
  input wire logic ack_i,
  // Request
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [31:0] dat_o
);
  // Idle bus at time zero.
  initial begin
    {cyc_o, stb_o, we_o, adr_o, dat_o} = '0;
  end
  // One access; the bench never pushes and pops an empty FIFO together.
  // It never trusts a collision read outside the single clock mode.
  // The wait has no limit of its own; only the bench watchdog ends a hang.
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, dat_o} <= {2'b11, w, a, d};
    do begin
      @(posedge clk_i);
    end while (!ack_i);
    // Released lines show junk so that stale values are never trusted.
    {cyc_o, stb_o, we_o, adr_o, dat_o} <= {3'b000, ~a, ~d};
  endtask
endmodule

//--- tb/test_embedded_ram_block.sv
// Self-checking bench for the embedded RAM block.
`timescale 1ns/1ps
module test_embedded_ram_block;
  // ----
  // Nets
  // ----
  logic clk_i, rst_i, ce_i, cyc, stb, we, ack;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, d0, d1;
  logic [1:0] be;
  logic [63:0] exp_q[$]; // Mask in the high half, expected data in the low half.
  logic [63:0] e;
  integer seed = 24908;
  int err_count = 0;
  int total_checks = 0;
  embedded_ram_block i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack));
  wb_user i_user (.clk_i(clk_i), .ack_i(ack), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .dat_o(wdat));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task wr(input logic [7:0] a, input logic [31:0] d);
    i_user.acc(1'b1, a, d);
  endtask
  // A read notes its expectation before it is issued.
  task rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
    exp_q.push_back({m, x});
    i_user.acc(1'b0, a, 32'h0);
  endtask
  // Compares each read answer with the oldest note.
  always @(posedge clk_i) begin
    if (ack && cyc && !we) begin
      e = exp_q.pop_front();
      total_checks++;
      if ((rdat & e[63:32]) !== (e[31:0] & e[63:32])) begin
        err_count++;
        $display("MISMATCH rd %h exp %h seen %h", adr, e[31:0], rdat);
      end
    end
  end
  task report_and_stop;
    if (exp_q.size() != 0) err_count++;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Watchdog far beyond the few hundred cycles the run needs.
  initial begin
    repeat (5000) @(posedge clk_i);
    err_count++;
    report_and_stop;
  end
  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ram_pkg::REG_CTRL, {25'h0, ram_pkg::CTRL_RESET}, 32'hffffffff);
    rd(ram_pkg::REG_CLKEN, 32'hf, 32'hffffffff);
    rd(ram_pkg::REG_RDATA, 32'h0, 32'hffffffff);
    rd(ram_pkg::REG_CMD, 32'h0, 32'hffffffff);
    rd(8'h24, 32'h0, 32'hffffffff);
    for (int i = 0; i < 3; i++) begin
      d0 = $random(seed);
      be = 2'(i + 1);
      wr(ram_pkg::REG_ADDR, d0);
      wr(ram_pkg::REG_BYTEEN, {28'h0, 2'h3, be});
      wr(ram_pkg::REG_WDATA, d0);
      wr(ram_pkg::REG_CMD, 32'h3);
      rd(ram_pkg::REG_RDATA, {16'h0, d0[15:0] & {{8{be[1]}}, {8{be[0]}}}}, 32'hffff);
    end
    wr(ram_pkg::REG_BYTEEN, 32'hf);
    for (int i = 0; i < 2; i++) begin
      d0 = $random(seed);
      d1 = $random(seed);
      wr(ram_pkg::REG_CTRL, {27'h0, i[0], 4'hc});
      wr(ram_pkg::REG_ADDR, {8'h0, d0[7:0], 8'h0, d0[7:0]});
      wr(ram_pkg::REG_WDATA, d0);
      wr(ram_pkg::REG_CMD, 32'h1);
      wr(ram_pkg::REG_WDATA, d1);
      wr(ram_pkg::REG_CMD, 32'h9);
      rd(ram_pkg::REG_RDATA, {(i == 0) ? d0[15:0] : 16'h0, 16'h0}, 32'hffff0000);
      rd(ram_pkg::REG_STATUS, 32'h800, 32'h800);
    end
    wr(ram_pkg::REG_CLKEN, 32'h0);
    wr(ram_pkg::REG_WDATA, ~d1);
    wr(ram_pkg::REG_CMD, 32'h3);
    ce_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    ce_i <= 1'b1;
    wr(ram_pkg::REG_CLKEN, 32'hf);
    wr(ram_pkg::REG_CMD, 32'h2);
    rd(ram_pkg::REG_RDATA, {16'h0, d1[15:0]}, 32'hffff);
    wr(ram_pkg::REG_CTRL, 32'h1);
    rd(ram_pkg::REG_CTRL, 32'hd, 32'hffffffff);
    wr(ram_pkg::REG_CTRL, 32'h8);
    rd(ram_pkg::REG_CTRL, 32'hc, 32'hffffffff);
    wr(ram_pkg::REG_CTRL, 32'h9);
    rd(ram_pkg::REG_CTRL, 32'h9, 32'hffffffff);
    wr(ram_pkg::REG_CMD, 32'h8);
    rd(ram_pkg::REG_RDATA, {d1[15:0], 16'h0}, 32'hffff0000);
    wr(ram_pkg::REG_CMD, 32'h1);
    rd(ram_pkg::REG_RDATA, {d1[15:0], 16'h0}, 32'hffff0000);
    // Input/output clocks: port A output group frozen while its input group reads.
    wr(ram_pkg::REG_CTRL, 32'h24);
    wr(ram_pkg::REG_CLKEN, 32'h1);
    wr(ram_pkg::REG_CMD, 32'h2);
    rd(ram_pkg::REG_RDATA, {16'h0, d1[15:0]}, 32'hffff);
    wr(ram_pkg::REG_CLKEN, 32'hf);
    rd(ram_pkg::REG_RDATA, {16'h0, ~d1[15:0]}, 32'hffff);
    // Independent clocks: port B ignores a read while only port A is enabled.
    wr(ram_pkg::REG_CTRL, 32'h0);
    wr(ram_pkg::REG_CLKEN, 32'h1);
    wr(ram_pkg::REG_CMD, 32'ha);
    rd(ram_pkg::REG_RDATA, {d1[15:0], ~d1[15:0]}, 32'hffffffff);
    // Single-port memory has no port B, so its read bit is dropped.
    wr(ram_pkg::REG_CTRL, 32'he);
    wr(ram_pkg::REG_CMD, 32'ha);
    rd(ram_pkg::REG_RDATA, {d1[15:0], ~d1[15:0]}, 32'hffffffff);
    wr(ram_pkg::REG_CTRL, 32'hf);
    rd(ram_pkg::REG_STATUS, 32'h200, 32'h7ff);
    wr(ram_pkg::REG_CMD, 32'h1);
    wr(ram_pkg::REG_CMD, 32'h1);
    wr(ram_pkg::REG_CMD, 32'h8);
    rd(ram_pkg::REG_STATUS, 32'h1, 32'h7ff);
    rd(ram_pkg::REG_RDATA, {~d1[15:0], 16'h0}, 32'hffff0000);
    // Let the checker take the last answer before the verdict.
    @(posedge clk_i);
    report_and_stop;
  end
endmodule
